// [verilog/cdfs_pkg.sv]
// Constants and types shared by the class-D fault supervisor
package cdfs_pkg;

    // ------------------------------------------------------------
    // Clock and off times
    // ------------------------------------------------------------
    localparam int unsigned CDFS_CLK_KHZ     = 40000;
    localparam int unsigned CDFS_OC_OFF_MS   = 1300;
    localparam int unsigned CDFS_OT_OFF_MS   = 1300;
    localparam int unsigned CDFS_DC_OFF_MS   = 650;
    localparam int unsigned CDFS_OC_OFF_CYC  = CDFS_OC_OFF_MS * CDFS_CLK_KHZ;
    localparam int unsigned CDFS_OT_OFF_CYC  = CDFS_OT_OFF_MS * CDFS_CLK_KHZ;
    localparam int unsigned CDFS_DC_OFF_CYC  = CDFS_DC_OFF_MS * CDFS_CLK_KHZ;
    localparam int unsigned CDFS_CNT_W       = 26;

    // ------------------------------------------------------------
    // Trip points (temperature in degC, voltages in 100 mV units)
    // ------------------------------------------------------------
    localparam int unsigned CDFS_TEMP_W      = 8;
    localparam int unsigned CDFS_TEMP_TRIP_C = 150;
    localparam int unsigned CDFS_TEMP_HYST_C = 15;
    localparam int unsigned CDFS_TEMP_REL_C  = CDFS_TEMP_TRIP_C - CDFS_TEMP_HYST_C;
    localparam int unsigned CDFS_VOLT_W      = 10;
    localparam int unsigned CDFS_SUPPLY_UV   = 45;
    localparam int unsigned CDFS_SUPPLY_OV   = 270;
    localparam int unsigned CDFS_DC_TRIP_PCT = 20;

    // ------------------------------------------------------------
    // Modulation
    // ------------------------------------------------------------
    localparam int unsigned CDFS_SAMPLE_W    = 8;
    localparam int unsigned CDFS_PWM_W       = 8;
    localparam int unsigned CDFS_IDLE_PCT    = 15;

    typedef enum logic {
        CDFS_IN_PHASE,
        CDFS_SINGLE_SIDE
    } cdfs_mode_t;

endpackage : cdfs_pkg

// [verilog/cdfs_pwm.sv]
// One bridge channel: duty computation and output switching
`timescale 1ns/1ps
module cdfs_pwm
    import cdfs_pkg::*;
#(
    parameter int unsigned SW = CDFS_SAMPLE_W,
    parameter int unsigned CW = CDFS_PWM_W
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Control
    input  wire cdfs_mode_t           mode,
    input  wire logic                 enable,
    input  wire logic [CW-1:0]        count,
    input  wire logic signed [SW-1:0] sample,
    // Bridge outputs
    output logic                      pos_out,
    output logic                      neg_out,
    output logic                      out_oe
);

    localparam int PERIOD = 2 ** CW;
    localparam int HALF   = PERIOD / 2;
    localparam int IDLE   = PERIOD * int'(CDFS_IDLE_PCT) / 100;

    function automatic logic [CW:0] duty_clamp(input int v);
        if (v < 0) begin
            return '0;
        end
        if (v > PERIOD) begin
            return (CW+1)'(PERIOD);
        end
        return (CW+1)'(v);
    endfunction : duty_clamp

    logic signed [SW-1:0] samp_reg;
    logic                 pos_reg;
    logic                 neg_reg;
    logic                 oe_reg;
    int                   s_val;
    int                   mag;
    logic [CW:0]          pos_duty;
    logic [CW:0]          neg_duty;
    logic [CW:0]          big_duty;
    logic [CW:0]          small_duty;

    // ------------------------------------------------------------
    // Duty selection
    // ------------------------------------------------------------
    assign s_val      = int'(samp_reg);
    assign mag        = (s_val < 0) ? -s_val : s_val;
    assign big_duty   = duty_clamp(IDLE + mag);
    assign small_duty = duty_clamp(IDLE - mag);
    assign pos_duty   = (mode == CDFS_IN_PHASE) ? duty_clamp(HALF + s_val)
                      : (s_val >= 0) ? big_duty : small_duty;
    assign neg_duty   = (mode == CDFS_IN_PHASE) ? duty_clamp(HALF - s_val)
                      : (s_val >= 0) ? small_duty : big_duty;

    // ------------------------------------------------------------
    // Output stage, sample taken once per period
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            samp_reg <= '0;
            pos_reg  <= 1'b0;
            neg_reg  <= 1'b0;
            oe_reg   <= 1'b0;
        end else begin
            if (count == '0) begin
                samp_reg <= sample;
            end
            pos_reg <= enable && ({1'b0, count} < pos_duty);
            neg_reg <= enable && ({1'b0, count} < neg_duty);
            oe_reg  <= enable;
        end
    end

    assign pos_out = pos_reg;
    assign neg_out = neg_reg;
    assign out_oe  = oe_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_IP_IDLE: assert property (enable && mode == CDFS_IN_PHASE && samp_reg == 0
        |=> pos_out == neg_out) else $error("in-phase idle outputs differ");
    AST_IP_POS: assert property (mode == CDFS_IN_PHASE && samp_reg > 0
        |-> pos_duty > HALF && neg_duty < HALF) else $error("positive duty wrong");
    AST_IP_NEG: assert property (mode == CDFS_IN_PHASE && samp_reg < 0
        |-> pos_duty < HALF && neg_duty > HALF) else $error("negative duty wrong");
    AST_SS_IDLE: assert property (mode == CDFS_SINGLE_SIDE && samp_reg == 0
        |-> pos_duty == IDLE && neg_duty == IDLE) else $error("idle duty wrong");
    AST_SS_RAIL: assert property (mode == CDFS_SINGLE_SIDE && s_val > IDLE
        |-> neg_duty == 0 && pos_duty == IDLE + s_val) else $error("single side rail wrong");
    AST_OFF: assert property (!enable |=> !out_oe && !pos_out && !neg_out)
        else $error("outputs switch while disabled");

endmodule : cdfs_pwm

// [verilog/cdfs_top.sv]
// Class-D fault supervisor: protection, auto-retry and bridge modulation
//
// Operation
// - Over-current: fault low, outputs high impedance
// - Over-current off 1.3 s, then auto re-enable
// - Above 150 degC: shutdown, fault low, 15 degC hysteresis
// - Thermal retry after 1.3 s only when cool
// - DC above 20% supply: shutdown, fault low
// - DC retry after 0.65 s when DC gone
// - Supply below 4.5 V: fault high, self-clearing
// - Supply above 27 V: fault high, self-clearing
// - In-phase mode: outputs switch together when idle
// - In-phase positive: positive duty above half
// - In-phase negative: negative duty above half
// - Single-side idle: both outputs near 15 percent
// - Single-side signal at or beyond the idle level: one output rails, other modulates
`timescale 1ns/1ps
module cdfs_top
    import cdfs_pkg::*;
#(
    parameter int unsigned OC_OFF_CYC = CDFS_OC_OFF_CYC,
    parameter int unsigned OT_OFF_CYC = CDFS_OT_OFF_CYC,
    parameter int unsigned DC_OFF_CYC = CDFS_DC_OFF_CYC,
    parameter int unsigned CNT_W      = CDFS_CNT_W,
    parameter int unsigned SW         = CDFS_SAMPLE_W,
    parameter int unsigned CW         = CDFS_PWM_W
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Asynchronous over-current detector and mode pins
    input  wire logic                   over_current_pin,
    input  wire logic                   single_side_switching_mode,
    // Sensor codes on this clock
    input  wire logic [CDFS_TEMP_W-1:0] die_temp_c,
    input  wire logic [CDFS_VOLT_W-1:0] power_stage_supply,
    input  wire logic [CDFS_VOLT_W-1:0] dc_level_left,
    input  wire logic [CDFS_VOLT_W-1:0] dc_level_right,
    // Audio samples on this clock
    input  wire logic signed [SW-1:0]   sample_left,
    input  wire logic signed [SW-1:0]   sample_right,
    // Bridge outputs
    output logic [1:0]                  positive_bridge_output,
    output logic [1:0]                  negative_bridge_output,
    output logic [1:0]                  bridge_oe,
    // Fault reporting
    output logic                        fault_indicator,
    output logic                        fault_active
);

    localparam logic [CNT_W-1:0] OC_LOAD = CNT_W'(OC_OFF_CYC - 1);
    localparam logic [CNT_W-1:0] OT_LOAD = CNT_W'(OT_OFF_CYC - 1);
    localparam logic [CNT_W-1:0] DC_LOAD = CNT_W'(DC_OFF_CYC - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic dc_over(input logic [CDFS_VOLT_W-1:0] lvl,
                                     input logic [CDFS_VOLT_W-1:0] sup);
        logic [17:0] lhs;
        logic [17:0] rhs;
        lhs = 18'(lvl) * 18'd100;
        rhs = 18'(sup) * 18'(CDFS_DC_TRIP_PCT);
        return lhs > rhs;
    endfunction : dc_over

    // Returns {shut, count}: trip loads the off time when not shut or at expiry, expiry releases when allowed
    function automatic logic [CNT_W:0] timer_step(input logic             trip,
                                                  input logic             ok,
                                                  input logic             shut,
                                                  input logic [CNT_W-1:0] cnt,
                                                  input logic [CNT_W-1:0] load);
        logic expire;
        expire = shut && (cnt == '0);
        if ((trip && (!shut || expire)) || (expire && !ok)) begin
            return {1'b1, load};
        end
        if (expire) begin
            return {1'b0, cnt};
        end
        if (shut) begin
            return {1'b1, cnt - 1'b1};
        end
        return {1'b0, cnt};
    endfunction : timer_step

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic oc_meta_reg;
    logic oc_sync_reg;
    logic mode_meta_reg;
    logic mode_sync_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            oc_meta_reg   <= 1'b0;
            oc_sync_reg   <= 1'b0;
            mode_meta_reg <= 1'b0;
            mode_sync_reg <= 1'b0;
        end else begin
            oc_meta_reg   <= over_current_pin;
            oc_sync_reg   <= oc_meta_reg;
            mode_meta_reg <= single_side_switching_mode;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Condition detection
    // ------------------------------------------------------------
    logic hot_reg;
    logic hot_next;
    logic dc_any;
    logic uv_det;
    logic ov_det;

    assign hot_next = (die_temp_c > CDFS_TEMP_W'(CDFS_TEMP_TRIP_C))
                   || (hot_reg && die_temp_c >= CDFS_TEMP_W'(CDFS_TEMP_REL_C));
    assign dc_any   = dc_over(dc_level_left, power_stage_supply)
                   || dc_over(dc_level_right, power_stage_supply);
    assign uv_det   = power_stage_supply < CDFS_VOLT_W'(CDFS_SUPPLY_UV);
    assign ov_det   = power_stage_supply > CDFS_VOLT_W'(CDFS_SUPPLY_OV);

    // ------------------------------------------------------------
    // Shutdown timers
    // ------------------------------------------------------------
    logic             oc_shut_reg;
    logic             ot_shut_reg;
    logic             dc_shut_reg;
    logic [CNT_W-1:0] oc_cnt_reg;
    logic [CNT_W-1:0] ot_cnt_reg;
    logic [CNT_W-1:0] dc_cnt_reg;
    logic [CNT_W:0]   oc_next;
    logic [CNT_W:0]   ot_next;
    logic [CNT_W:0]   dc_next;
    logic             latched_next;
    logic             ok_next;

    assign oc_next = timer_step(oc_sync_reg, 1'b1, oc_shut_reg,
                                oc_cnt_reg, OC_LOAD);
    assign ot_next = timer_step(hot_next && !hot_reg, !hot_next,
                                ot_shut_reg, ot_cnt_reg, OT_LOAD);
    assign dc_next = timer_step(dc_any, !dc_any, dc_shut_reg,
                                dc_cnt_reg, DC_LOAD);

    assign latched_next = oc_next[CNT_W] || ot_next[CNT_W] || dc_next[CNT_W];
    assign ok_next      = !latched_next && !uv_det && !ov_det;

    // ------------------------------------------------------------
    // State and fault outputs
    // ------------------------------------------------------------
    logic oe_reg;
    logic fault_reg;
    logic active_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            hot_reg     <= 1'b0;
            oc_shut_reg <= 1'b0;
            ot_shut_reg <= 1'b0;
            dc_shut_reg <= 1'b0;
            oc_cnt_reg  <= '0;
            ot_cnt_reg  <= '0;
            dc_cnt_reg  <= '0;
            oe_reg      <= 1'b0;
            fault_reg   <= 1'b1;
            active_reg  <= 1'b0;
        end else begin
            hot_reg     <= hot_next;
            oc_shut_reg <= oc_next[CNT_W];
            ot_shut_reg <= ot_next[CNT_W];
            dc_shut_reg <= dc_next[CNT_W];
            oc_cnt_reg  <= oc_next[CNT_W-1:0];
            ot_cnt_reg  <= ot_next[CNT_W-1:0];
            dc_cnt_reg  <= dc_next[CNT_W-1:0];
            oe_reg      <= ok_next;
            fault_reg   <= !latched_next;
            active_reg  <= !ok_next;
        end
    end

    assign fault_indicator = fault_reg;
    assign fault_active    = active_reg;

    // ------------------------------------------------------------
    // Modulation
    // ------------------------------------------------------------
    logic [CW-1:0] pwm_cnt_reg;
    cdfs_mode_t    mode_sel;

    assign mode_sel = mode_sync_reg ? CDFS_SINGLE_SIDE : CDFS_IN_PHASE;

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt_reg <= '0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
        end
    end

    cdfs_pwm #(
        .SW (SW),
        .CW (CW)
    ) u_left (
        .clk     (clk),
        .rst     (rst),
        .mode    (mode_sel),
        .enable  (oe_reg),
        .count   (pwm_cnt_reg),
        .sample  (sample_left),
        .pos_out (positive_bridge_output[0]),
        .neg_out (negative_bridge_output[0]),
        .out_oe  (bridge_oe[0])
    );

    cdfs_pwm #(
        .SW (SW),
        .CW (CW)
    ) u_right (
        .clk     (clk),
        .rst     (rst),
        .mode    (mode_sel),
        .enable  (oe_reg),
        .count   (pwm_cnt_reg),
        .sample  (sample_right),
        .pos_out (positive_bridge_output[1]),
        .neg_out (negative_bridge_output[1]),
        .out_oe  (bridge_oe[1])
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_shut_off;
        !oe_reg && !fault_reg && fault_active;
    endsequence

    sequence s_supply_off;
        !oe_reg && fault_reg && fault_active;
    endsequence

    AST_OC_TRIP: assert property (oc_sync_reg |=> s_shut_off)
        else $error("over-current did not shut outputs");
    AST_OC_LOAD: assert property ($rose(oc_shut_reg) |-> oc_cnt_reg == OC_LOAD)
        else $error("over-current off time not loaded");
    AST_OC_RETRY: assert property (oc_shut_reg && oc_cnt_reg == 0 && !oc_sync_reg
        |=> !oc_shut_reg) else $error("over-current did not retry");
    AST_OT_TRIP: assert property (die_temp_c > CDFS_TEMP_TRIP_C |=> s_shut_off)
        else $error("over-temperature did not shut outputs");
    AST_OT_HYST: assert property (hot_reg && die_temp_c >= CDFS_TEMP_REL_C
        |=> hot_reg) else $error("thermal hysteresis lost");
    AST_OT_HOLD: assert property (ot_shut_reg && ot_cnt_reg == 0 && hot_next
        |=> ot_shut_reg && ot_cnt_reg == OT_LOAD) else $error("hot release");
    AST_DC_TRIP: assert property (dc_any |=> s_shut_off)
        else $error("DC offset did not shut outputs");
    AST_DC_HOLD: assert property (dc_shut_reg && !dc_any && dc_cnt_reg > 1
        |=> dc_shut_reg) else $error("DC off time cut short");
    AST_UV: assert property (uv_det && !latched_next |=> s_supply_off)
        else $error("under-voltage not reported");
    AST_OV: assert property (ov_det && !latched_next |=> s_supply_off)
        else $error("over-voltage not reported");
    AST_SUPPLY_CLEAR: assert property (!uv_det && !ov_det && !latched_next
        |=> oe_reg) else $error("supply fault did not clear");
    AST_ALL_CLEAR: assert property (oc_shut_reg || ot_shut_reg || dc_shut_reg
        |-> !oe_reg) else $error("outputs on with a fault pending");

    // Pins follow the shutdown one edge later
    sequence s_pins_off;
        bridge_oe == 2'h0 && positive_bridge_output == 2'h0 && negative_bridge_output == 2'h0;
    endsequence

    AST_PINS_OFF: assert property (!oe_reg |=> s_pins_off)
        else $error("bridge pins driven while shut down");
    AST_SUPPLY_FI: assert property ((uv_det || ov_det) && !latched_next
        |=> fault_indicator && fault_active)
        else $error("supply fault indicator level wrong");

    // Off time runs down without restarting
    AST_OC_COUNT: assert property (oc_shut_reg && oc_cnt_reg != 0
        |=> oc_shut_reg && oc_cnt_reg == $past(oc_cnt_reg) - 1)
        else $error("over-current off time not counting");
    AST_OT_COOL: assert property (die_temp_c < CDFS_TEMP_REL_C
        |=> !hot_reg)
        else $error("thermal flag held below release point");
    AST_OT_RETRY: assert property (ot_shut_reg && ot_cnt_reg == 0 && !hot_next
        |=> !ot_shut_reg)
        else $error("thermal shutdown did not retry");

    // Expiry releases or reloads
    AST_DC_RETRY: assert property (dc_shut_reg && dc_cnt_reg == 0 && !dc_any
        |=> !dc_shut_reg)
        else $error("DC shutdown did not retry");
    AST_DC_RELOAD: assert property (dc_shut_reg && dc_cnt_reg == 0 && dc_any
        |=> dc_shut_reg && dc_cnt_reg == DC_LOAD)
        else $error("DC off time not reloaded");

endmodule : cdfs_top

// [tb/cdfs_load_model.sv]
// Bridge-tied loudspeaker load with short detector and duty meter
`timescale 1ns/1ps
module cdfs_load_model (
    // Clock
    input  wire logic             clk,
    // Bridge side
    input  wire logic [1:0]       pos_out,
    input  wire logic [1:0]       neg_out,
    input  wire logic [1:0]       oe,
    // Bench control
    input  wire logic             short_cmd,
    input  wire logic             clr,
    // Monitor outputs
    output logic                  over_current_pin,
    output logic [1:0][9:0]       pos_hi,
    output logic [1:0][9:0]       neg_hi,
    output logic [1:0][9:0]       skew
);
    // --------------------------------------------------------
    // Short only draws current while a bridge is driven
    // --------------------------------------------------------
    assign over_current_pin = short_cmd && (|oe);

    // --------------------------------------------------------
    // High-time and mismatch counters per channel
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (clr) begin
                pos_hi[c] <= 10'h000;
                neg_hi[c] <= 10'h000;
                skew[c]   <= 10'h000;
            end else begin
                pos_hi[c] <= pos_hi[c] + 10'(pos_out[c] & oe[c]);
                neg_hi[c] <= neg_hi[c] + 10'(neg_out[c] & oe[c]);
                skew[c]   <= skew[c] + 10'(pos_out[c] ^ neg_out[c]);
            end
        end
    end
endmodule : cdfs_load_model

// [tb/class_d_fault_supervisor_test.sv]
// Self-checking bench for the class-D fault supervisor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module class_d_fault_supervisor_test;
    import cdfs_pkg::*;
    localparam int OC = 20;
    localparam int OT = 20;
    localparam int DC = 10;
    logic             clk = 0;
    logic             rst = 1;
    logic             short_cmd = 0;
    logic             clr = 0;
    logic             oc_pin;
    logic             ss_mode = 0;
    logic [7:0]       temp = 8'h19;
    logic [9:0]       supply = 10'h078;
    logic [9:0]       dc_l = 10'h000;
    logic [9:0]       dc_r = 10'h000;
    logic signed [7:0] smp_l = 8'h00;
    logic signed [7:0] smp_r = 8'h00;
    logic [1:0]       pos_o, neg_o, oe;
    logic             fi, fa;
    logic [1:0][9:0]  pos_hi, neg_hi, skew;
    int               err_count = 0;
    int               n_checks = 0;
    logic [31:0]      rng = 32'd93041;

    always #12.5 clk = ~clk;

    cdfs_top #(.OC_OFF_CYC(OC), .OT_OFF_CYC(OT), .DC_OFF_CYC(DC)) DUT (
        .clk(clk), .rst(rst), .over_current_pin(oc_pin),
        .single_side_switching_mode(ss_mode), .die_temp_c(temp),
        .power_stage_supply(supply), .dc_level_left(dc_l), .dc_level_right(dc_r),
        .sample_left(smp_l), .sample_right(smp_r), .positive_bridge_output(pos_o),
        .negative_bridge_output(neg_o), .bridge_oe(oe), .fault_indicator(fi),
        .fault_active(fa));

    cdfs_load_model load (
        .clk(clk), .pos_out(pos_o), .neg_out(neg_o), .oe(oe), .short_cmd(short_cmd),
        .clr(clr), .over_current_pin(oc_pin), .pos_hi(pos_hi), .neg_hi(neg_hi),
        .skew(skew));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return int'(rng % 255) - 127;
    endfunction : xs

    function automatic logic [9:0] exp_duty(logic ss, int s);
        int idle;
        idle = (1 << CDFS_PWM_W) * CDFS_IDLE_PCT / 100;
        if (!ss) return 10'((1 << (CDFS_PWM_W - 1)) + s);
        return (idle + s < 0) ? 10'h000 : 10'(idle + s);
    endfunction : exp_duty

    task automatic end_of_test();
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Wait for oe (sel 0) or fault indicator (sel 1) to reach v
    task automatic wait_for(bit sel, logic [1:0] v, int bound);
        for (int i = 0; i < bound; i++) begin
            if ((sel ? {1'b0, fi} : oe) === v) return;
            @(negedge clk);
        end
        err_count++;
        $display("unexpected wait: sel %0d never reached %0h", sel, v);
        end_of_test();
    endtask : wait_for

    // Count cycles of fault indicator low, then expect outputs back
    task automatic off_time(int exp);
        int n;
        n = 0;
        while (fi === 1'b0 && n < 4 * exp) begin
            n++;
            @(negedge clk);
        end
        `CHK("off time in range", 1'b1, (n >= exp - 1 && n <= exp + 1))
        wait_for(0, 2'h3, 5);
    endtask : off_time

    task automatic duty(logic ss, int sl, int sr);
        ss_mode = ss;
        smp_l = 8'(sl);
        smp_r = 8'(sr);
        cyc(600);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(256);
        `CHK("pos duty left", exp_duty(ss, sl), pos_hi[0])
        `CHK("neg duty left", exp_duty(ss, -sl), neg_hi[0])
        `CHK("pos duty right", exp_duty(ss, sr), pos_hi[1])
        `CHK("neg duty right", exp_duty(ss, -sr), neg_hi[1])
        if (!ss && sl == 0) `CHK("idle skew", 10'h000, skew[0])
    endtask : duty

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(20);
        `CHK("oe in reset", 2'h0, oe)
        `CHK("fault indicator in reset", 1'b1, fi)
        `CHK("fault active in reset", 1'b0, fa)
        rst = 0;
        wait_for(0, 2'h3, 50);
        `CHK("fault indicator idle", 1'b1, fi)
        `CHK("fault active idle", 1'b0, fa)
        // Over-current trip and auto retry
        short_cmd = 1;
        wait_for(0, 2'h0, 10);
        `CHK("fault indicator on short", 1'b0, fi)
        `CHK("fault active on short", 1'b1, fa)
        short_cmd = 0;
        off_time(OC);
        // Thermal: boundary, trip, hysteresis hold, release
        temp = 8'h96;
        cyc(10);
        `CHK("oe at trip point", 2'h3, oe)
        temp = 8'h97;
        wait_for(1, 2'h0, 10);
        cyc(1);
        `CHK("oe hot", 2'h0, oe)
        temp = 8'h8C;
        cyc(3 * OT);
        `CHK("oe warm after off time", 2'h0, oe)
        temp = 8'h64;
        wait_for(0, 2'h3, 2 * OT + 10);
        // DC offset: boundary then trip on right channel
        dc_r = 10'h018;
        cyc(10);
        `CHK("oe at dc boundary", 2'h3, oe)
        dc_r = 10'h019;
        wait_for(1, 2'h0, 10);
        cyc(1);
        `CHK("oe dc trip", 2'h0, oe)
        dc_r = 10'h000;
        off_time(DC);
        // DC on left channel outlasting its off time
        dc_l = 10'h019;
        wait_for(1, 2'h0, 10);
        `CHK("fault active dc left", 1'b1, fa)
        cyc(2 * DC);
        `CHK("oe dc held", 2'h0, oe)
        dc_l = 10'h000;
        wait_for(0, 2'h3, 2 * DC + 10);
        // Under and over voltage
        supply = 10'h02C;
        wait_for(0, 2'h0, 10);
        `CHK("fault indicator uv", 1'b1, fi)
        `CHK("fault active uv", 1'b1, fa)
        supply = 10'h02D;
        wait_for(0, 2'h3, 10);
        supply = 10'h10F;
        wait_for(0, 2'h0, 10);
        `CHK("fault indicator ov", 1'b1, fi)
        supply = 10'h10E;
        wait_for(0, 2'h3, 10);
        // Over-current followed by under voltage outlasting its off time
        supply = 10'h078;
        short_cmd = 1;
        wait_for(1, 2'h0, 10);
        short_cmd = 0;
        supply = 10'h02C;
        cyc(2 * OC);
        `CHK("oe multi fault", 2'h0, oe)
        `CHK("fault active multi", 1'b1, fa)
        supply = 10'h078;
        wait_for(0, 2'h3, 10);
        // Modulation: corners then random samples in both modes
        for (int m = 0; m < 2; m++) begin
            duty(m[0], 0, 0);
            duty(m[0], 127, -127);
            duty(m[0], -127, 5);
            for (int k = 0; k < 4; k++) duty(m[0], xs(), xs());
        end
        end_of_test();
    end
endmodule : class_d_fault_supervisor_test
